// File: hw/flash_ctl_consts.svh
`ifndef FLASH_CTL_CONSTS_SVH
`define FLASH_CTL_CONSTS_SVH
`define OFS_FLASH_OPTION_WORKING 14'h0210
`define OFS_FLASH_CONTROL 14'h0211
`define OFS_PAGE_SELECT 14'h0212
`define OFS_FLASH_OPTION_NONVOLATILE 14'h3ffc
`define WINDOW_LO 14'h00c0
`define WINDOW_HI 14'h00ff
`define FLASH_BASE 14'h2000
`define BIT_PROGRAM_SELECT 0
`define BIT_MASS_ERASE 2
`define BIT_HIGH_VOLTAGE 3
`define BIT_SECURITY_CODE 0
`define ROW_BYTES 7'h40
`define RESET_PAGE_SELECT 8'h00
`define RESET_OPTION_WORKING 8'h01
`endif

// File: hw/flash_ctl_pkg.sv
package flash_ctl_pkg;
    typedef enum logic [1:0] {
        seq_idle = 2'b00,
        seq_armed = 2'b01,
        seq_high_voltage = 2'b11
    } seq_state_t;
    typedef logic [13:0] addr_t;
    typedef logic [7:0] byte_t;
endpackage : flash_ctl_pkg

// File: hw/flash_program_erase_security.sv
// Functional notes
// - rows are 64 bytes, row base aligned on 64 within flash pages.
// - program-select arms latching of address and data from later writes.
// - each reset copies nonvolatile option byte into working option register.
// - security code 0 engaged, 1 disengaged; erased state unsecured.
// - new security code takes effect only at next reset.
// - only mass erase plus reset removes security.
// - working option register reads zero in 7..1, ignores writes.
// - high voltage set only when program or erase selected and armed.
// - program-select and mass-erase never both one.
// - secured device ignores writes to program-select.
// - secured normal boot clears debug-pin enable, blocks debug.
// - security guards only flash; RAM and registers stay reachable.
// - page select supplies address bits 13..6 of the window.
`timescale 1ns/1ns
`default_nettype none
`include "flash_ctl_consts.svh"
module flash_program_erase_security (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [13:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic cpu_from_debug,
    output logic [7:0] cpu_rdata,
    input wire logic mode_select_pin,
    input wire logic debug_pin_enable_wr,
    input wire logic debug_pin_enable_in,
    output logic debug_pin_enable,
    output logic debug_blocked,
    input wire logic [7:0] array_rdata,
    output logic [13:0] array_addr,
    output logic array_rd,
    output logic array_latch,
    output logic [7:0] array_wdata,
    output logic array_program,
    output logic array_mass_erase,
    output logic array_high_voltage
);
    import flash_ctl_pkg::*;

    seq_state_t state;
    logic program_select;
    logic mass_erase;
    logic high_voltage_enable;
    logic security_code;
    logic [7:0] page_select;
    logic loading;
    logic mode_meta;
    logic mode_sync;
    logic [13:0] phys_addr;
    logic in_flash;
    logic secured;
    logic sel_ctl;
    logic flash_wr;
    logic [7:0] ctl_value;
    logic want_pgm;
    logic want_mass;
    logic want_hv;
    logic flash_rd_pending;
    logic flash_rd_blocked;

    window_map u_map (
        .cpu_addr(cpu_addr),
        .page_select(page_select),
        .phys_addr(phys_addr),
        .in_flash(in_flash)
    );

    assign secured = ~security_code;
    assign sel_ctl = cpu_wr && (cpu_addr == `OFS_FLASH_CONTROL);
    assign flash_wr = cpu_wr && in_flash;
    assign want_pgm = cpu_wdata[`BIT_PROGRAM_SELECT];
    assign want_mass = cpu_wdata[`BIT_MASS_ERASE];
    assign want_hv = cpu_wdata[`BIT_HIGH_VOLTAGE];

    // mode pin crosses in from outside
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode_meta <= 1'b0;
            mode_sync <= 1'b0;
        end else begin
            mode_meta <= mode_select_pin;
            mode_sync <= mode_meta;
        end
    end

    // option byte fetched in the first cycle after reset release
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            loading <= 1'b1;
            security_code <= 1'b1;
        end else if (loading) begin
            loading <= 1'b0;
            // only sampled here, so reprogramming waits for a reset
            security_code <= array_rdata[`BIT_SECURITY_CODE];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            debug_pin_enable <= 1'b0;
            debug_blocked <= 1'b0;
        end else if (loading) begin
            debug_pin_enable <= 1'b0;
            debug_blocked <= 1'b0;
        end else if (secured && mode_sync) begin
            // normal boot with security: debug shut out
            debug_pin_enable <= 1'b0;
            debug_blocked <= 1'b1;
        end else if (debug_pin_enable_wr && !debug_blocked) begin
            // stays shut until the next reset, even if the mode pin drops
            debug_pin_enable <= debug_pin_enable_in;
        end
    end

    // page select is ordinary register, unaffected by security
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            page_select <= `RESET_PAGE_SELECT;
        end else if (cpu_wr && cpu_addr == `OFS_PAGE_SELECT) begin
            page_select <= cpu_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            program_select <= 1'b0;
            mass_erase <= 1'b0;
        end else if (sel_ctl) begin
            // setting both at once is refused; either held blocks the other
            if (!(want_pgm && want_mass)) begin
                if (!secured && !(want_pgm && mass_erase)) begin
                    program_select <= want_pgm;
                end
                if (!(want_mass && program_select)) begin
                    mass_erase <= want_mass;
                end
            end
        end
    end

    // armed only after a flash write while selected
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= seq_idle;
        end else begin
            case (state)
                seq_idle: begin
                    if (flash_wr && (program_select || mass_erase)) begin
                        state <= seq_armed;
                    end
                end
                seq_armed: begin
                    if (!program_select && !mass_erase) begin
                        state <= seq_idle;
                    end else if (high_voltage_enable) begin
                        state <= seq_high_voltage;
                    end
                end
                seq_high_voltage: begin
                    if (!high_voltage_enable) begin
                        state <= seq_idle;
                    end
                end
                default: state <= seq_idle;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            high_voltage_enable <= 1'b0;
        end else if (sel_ctl) begin
            if (!want_hv) begin
                high_voltage_enable <= 1'b0;
            end else if ((program_select || mass_erase) && state != seq_idle) begin
                high_voltage_enable <= 1'b1;
            end
        end
    end

    // latch address/data of flash writes while program or mass erase selected
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            // parked on the option byte so the first-cycle fetch reads it
            array_addr <= `OFS_FLASH_OPTION_NONVOLATILE;
            array_wdata <= 8'h00;
            array_latch <= 1'b0;
        end else begin
            array_latch <= flash_wr && (program_select || mass_erase);
            if (flash_wr && (program_select || mass_erase)) begin
                array_addr <= phys_addr;
                array_wdata <= cpu_wdata;
            end else if (loading) begin
                array_addr <= `OFS_FLASH_OPTION_NONVOLATILE;
            end else if (cpu_rd) begin
                array_addr <= phys_addr;
            end
        end
    end

    // array address is registered, so its data is taken one edge after the read
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flash_rd_pending <= 1'b0;
            flash_rd_blocked <= 1'b0;
        end else begin
            flash_rd_pending <= cpu_rd && in_flash;
            flash_rd_blocked <= secured && (cpu_from_debug || debug_pin_enable);
        end
    end

    assign array_rd = loading || flash_rd_pending;
    assign array_program = program_select;
    assign array_mass_erase = mass_erase;
    assign array_high_voltage = high_voltage_enable;

    assign ctl_value = {4'h0, high_voltage_enable, mass_erase, 1'b0, program_select};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd && !in_flash) begin
            if (cpu_addr == `OFS_FLASH_OPTION_WORKING) begin
                cpu_rdata <= {7'h00, security_code};
            end else if (cpu_addr == `OFS_FLASH_CONTROL) begin
                cpu_rdata <= ctl_value;
            end else if (cpu_addr == `OFS_PAGE_SELECT) begin
                cpu_rdata <= page_select;
            end else begin
                cpu_rdata <= 8'h00;
            end
        end else if (flash_rd_pending) begin
            // a register read in this cycle wins, so leave a gap after flash reads
            cpu_rdata <= flash_rd_blocked ? 8'h00 : array_rdata;
        end
    end
endmodule : flash_program_erase_security
`default_nettype wire

// File: hw/window_map.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_ctl_consts.svh"
module window_map (
    input wire logic [13:0] cpu_addr,
    input wire logic [7:0] page_select,
    output logic [13:0] phys_addr,
    output logic in_flash
);
    logic in_window;
    assign in_window = (cpu_addr >= `WINDOW_LO) && (cpu_addr <= `WINDOW_HI);
    // page picks address bits 13..6 of the 64-byte block
    assign phys_addr = in_window ? {page_select, cpu_addr[5:0]} : cpu_addr;
    // flash occupies the upper half of the map
    assign in_flash = phys_addr[13];
endmodule : window_map
`default_nettype wire

// File: sim/flash_array_model.sv
`timescale 1ns/1ns
`default_nettype none
module flash_array_model (
    input wire logic [13:0] array_addr,
    input wire logic array_rd,
    input wire logic [7:0] option_byte,
    output logic [7:0] array_rdata
);
    // only the option byte holds it; idle bus and other cells inverted so a missed fetch shows
    assign array_rdata = (array_rd && array_addr == 14'h3ffc) ?
        option_byte : ~option_byte;
endmodule : flash_array_model
`default_nettype wire

// File: sim/flash_ctl_properties.sv
`timescale 1ns/1ns
`default_nettype none
module flash_ctl_properties (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [13:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_rdata,
    input wire logic debug_pin_enable,
    input wire logic debug_blocked,
    input wire logic [13:0] array_addr,
    input wire logic array_latch,
    input wire logic [7:0] array_wdata,
    input wire logic array_program,
    input wire logic array_mass_erase,
    input wire logic array_high_voltage
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_ctl_rd;
        cpu_rd && cpu_addr == 14'h0211;
    endsequence
    a_select_interlock: assert property (!(array_program && array_mass_erase))
        else $error("program and erase both set");
    a_hv_needs_select: assert property ($rose(array_high_voltage) |-> array_program || array_mass_erase)
        else $error("high voltage without select");
    a_option_upper_zero: assert property (cpu_rd && cpu_addr == 14'h0210 |=> cpu_rdata[7:1] == 7'h00)
        else $error("option upper bits not zero");
    a_latch_from_write: assert property (array_latch |-> $past(cpu_wr) && array_wdata == $past(cpu_wdata))
        else $error("latch without matching write");
    a_latch_low_bits: assert property (array_latch |-> array_addr[5:0] == $past(cpu_addr[5:0]))
        else $error("latched offset wrong");
    a_latch_in_flash: assert property (array_latch |-> array_addr[13] && (array_program || array_mass_erase))
        else $error("latch outside flash or unselected");
    a_blocked_pin_off: assert property (debug_blocked |-> !debug_pin_enable)
        else $error("debug pin enabled while blocked");
    a_ctl_readback: assert property (s_ctl_rd |=> cpu_rdata == {4'h0, $past(array_high_voltage),
        $past(array_mass_erase), 1'b0, $past(array_program)})
        else $error("control readback wrong");
endmodule : flash_ctl_properties
bind flash_program_erase_security flash_ctl_properties u_props (.sys_clk, .nrst, .cpu_addr,
    .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata, .debug_pin_enable, .debug_blocked, .array_addr,
    .array_latch, .array_wdata, .array_program, .array_mass_erase, .array_high_voltage);
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import flash_ctl_pkg::*;
    typedef struct packed {addr_t addr; byte_t data; byte_t ctl;} row_t;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cpu_wr = 1'b0;
    logic cpu_rd = 1'b0;
    logic mode_select_pin = 1'b0;
    logic cpu_from_debug = 1'b0;
    logic debug_pin_enable_wr = 1'b0;
    logic debug_pin_enable_in = 1'b0;
    localparam int host_wait = 2;
    addr_t cpu_addr = 14'h0000;
    byte_t cpu_wdata = 8'h00;
    byte_t option_byte = 8'h01;
    byte_t cpu_rdata, array_rdata, array_wdata;
    addr_t array_addr;
    logic debug_pin_enable, debug_blocked, array_rd, array_latch, array_program;
    logic array_mass_erase, array_high_voltage;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    // host runs from ram with supply on, never sleeps, keeps the order
    // program and erase steps, delays as short cycle counts
    row_t rows [14] = '{'{14'h0211, 8'h05, 8'h00}, '{14'h0211, 8'h08, 8'h00},
        '{14'h0211, 8'h01, 8'h01}, '{14'h0211, 8'h09, 8'h01}, '{14'h00c5, 8'ha5, 8'h01},
        '{14'h0211, 8'h09, 8'h09}, '{14'h00c6, 8'h3c, 8'h09}, '{14'h0211, 8'h08, 8'h08},
        '{14'h0211, 8'h00, 8'h00}, '{14'h0211, 8'h04, 8'h04}, '{14'h00c0, 8'h11, 8'h04},
        '{14'h0211, 8'h0c, 8'h0c}, '{14'h0211, 8'h08, 8'h08}, '{14'h0211, 8'h00, 8'h00}};
    always #10 sys_clk = ~sys_clk;
    flash_program_erase_security u_flash_program_erase_security (.sys_clk, .nrst, .cpu_addr,
        .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_from_debug, .cpu_rdata, .mode_select_pin,
        .debug_pin_enable_wr, .debug_pin_enable_in, .debug_pin_enable,
        .debug_blocked, .array_rdata, .array_addr, .array_rd, .array_latch, .array_wdata,
        .array_program, .array_mass_erase, .array_high_voltage);
    flash_array_model u_flash_array_model (.array_addr, .array_rd, .option_byte, .array_rdata);
    task final_report;
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task check(input logic [13:0] got, input logic [13:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task wr(input addr_t a, input byte_t d);
        @(posedge sys_clk) begin cpu_addr <= a; cpu_wdata <= d; cpu_wr <= 1'b1; end
        @(posedge sys_clk) cpu_wr <= 1'b0;
        #1;
    endtask : wr
    task rd(input addr_t a, input byte_t e);
        @(posedge sys_clk) begin cpu_addr <= a; cpu_rd <= 1'b1; end
        @(posedge sys_clk) cpu_rd <= 1'b0;
        #1 check({6'h00, cpu_rdata}, {6'h00, e});
    endtask : rd
    // flash data arrives one edge later than register data
    task rd_flash(input addr_t a, input logic dbg, input byte_t e);
        @(posedge sys_clk) begin cpu_addr <= a; cpu_rd <= 1'b1; cpu_from_debug <= dbg; end
        @(posedge sys_clk) begin cpu_rd <= 1'b0; cpu_from_debug <= 1'b0; end
        @(posedge sys_clk) #1 check({6'h00, cpu_rdata}, {6'h00, e});
    endtask : rd_flash
    task set_pin(input logic v);
        @(posedge sys_clk) begin debug_pin_enable_wr <= 1'b1; debug_pin_enable_in <= v; end
        @(posedge sys_clk) debug_pin_enable_wr <= 1'b0;
        #1;
    endtask : set_pin
    task do_reset(input byte_t opt, input logic ms);
        option_byte <= opt;
        mode_select_pin <= ms;
        nrst <= 1'b0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask : do_reset
    // cut a hang well past the under two hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        do_reset(8'h01, 1'b0);
        rd(14'h0210, 8'h01);
        wr(14'h0210, 8'h00);
        rd(14'h0210, 8'h01);
        wr(14'h0212, 8'h80);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].data);
            if (rows[i].addr[13:6] == 8'h03) begin
                check(array_addr, 14'h2000 | rows[i].addr[5:0]);
                check({6'h00, array_wdata}, {6'h00, rows[i].data});
            end
            repeat (host_wait) @(posedge sys_clk);
            rd(14'h0211, rows[i].ctl);
        end
        set_pin(1'b1);
        check({13'h0, debug_pin_enable}, 14'h0001);
        wr(14'h0212, 8'hff);
        rd_flash(14'h00fc, 1'b1, 8'h01);
        set_pin(1'b0);
        do_reset(8'h00, 1'b0);
        rd(14'h0210, 8'h00);
        wr(14'h0212, 8'hff);
        rd_flash(14'h00c0, 1'b0, 8'hff);
        rd_flash(14'h00c0, 1'b1, 8'h00);
        set_pin(1'b1);
        rd_flash(14'h00c0, 1'b0, 8'h00);
        rd(14'h0212, 8'hff);
        set_pin(1'b0);
        wr(14'h0211, 8'h01);
        rd(14'h0211, 8'h00);
        wr(14'h0211, 8'h04);
        rd(14'h0211, 8'h04);
        wr(14'h0211, 8'h00);
        option_byte <= 8'h01;
        rd(14'h0210, 8'h00);
        do_reset(8'h01, 1'b0);
        rd(14'h0210, 8'h01);
        do_reset(8'h00, 1'b1);
        // mode pin needs two sync edges, the block a third
        @(posedge sys_clk) #1 check({13'h0, debug_blocked}, 14'h0001);
        check({13'h0, debug_pin_enable}, 14'h0000);
        set_pin(1'b1);
        check({13'h0, debug_pin_enable}, 14'h0000);
        final_report();
    end
endmodule : testbench
`default_nettype wire
